// [bench/touch_sensor_i2c_register_port_bench.sv]
// self-checking bench: host end and sensor end joined over the link
`timescale 1ns/1ns
`include "tsi_regs.svh"
module touch_sensor_i2c_register_port_bench;
  typedef struct packed {logic [11:0] cmd; logic nack; logic [7:0] rx;} tsi_row_t;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic hsel = 1'b0, hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, st;
  logic [7:0] rd_index = 8'h00;
  wire hready, hresp, wr_pulse, dev_busy;
  wire [31:0] hrdata;
  wire [7:0] rd_data, wr_index, wr_data;
  int n_errors = 0, checks = 0;
  int n_wr = 0;
  // command, expected ack bit and byte seen on the wire
  localparam tsi_row_t ROWS [28] = '{
    '{12'h1f0, 1'b0, 8'hf0}, '{12'h002, 1'b0, 8'h02}, '{12'h033, 1'b0, 8'h33}, '{12'h222, 1'b0, 8'h22},
    '{12'h1f0, 1'b0, 8'hf0}, '{12'h202, 1'b0, 8'h02},
    '{12'h1f1, 1'b0, 8'hf1}, '{12'h400, 1'b0, 8'h33}, '{12'he00, 1'b1, 8'h22},
    '{12'h3f2, 1'b1, 8'hf2}, '{12'h3f3, 1'b1, 8'hf3},
    '{12'h1f0, 1'b0, 8'hf0}, '{12'h003, 1'b0, 8'h03}, '{12'h1f1, 1'b0, 8'hf1}, '{12'he00, 1'b1, 8'h22},
    '{12'h1f0, 1'b0, 8'hf0}, '{12'h0ff, 1'b0, 8'hff}, '{12'h05a, 1'b0, 8'h5a}, '{12'h2a5, 1'b0, 8'ha5},
    '{12'h1f0, 1'b0, 8'hf0}, '{12'h2fe, 1'b0, 8'hfe}, '{12'h1f1, 1'b0, 8'hf1},
    '{12'h400, 1'b0, 8'h00}, '{12'h400, 1'b0, 8'h00}, '{12'h400, 1'b0, 8'ha5}, '{12'h400, 1'b0, 8'h00},
    '{12'h400, 1'b0, 8'h33}, '{12'he00, 1'b1, 8'h22}
  };
  tsi_if tsi_if_inst ();
  tsi_host tsi_host_inst (.clk_i(clk_i), .reset_i(reset_i), .link(tsi_if_inst.host), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hready), .hreadyout_o(hready), .hrdata_o(hrdata), .hresp_o(hresp));
  tsi_dev tsi_dev_inst (.clk_i(clk_i), .reset_i(reset_i), .link(tsi_if_inst.dev), .rd_index_i(rd_index),
    .rd_data_o(rd_data), .wr_pulse_o(wr_pulse), .wr_index_o(wr_index), .wr_data_o(wr_data), .busy_o(dev_busy));
  tsi_link_asserts tsi_link_asserts_inst (.clk_i(clk_i), .reset_i(reset_i),
    .host_scl_oe(tsi_if_inst.host_scl_oe), .host_sda_oe(tsi_if_inst.host_sda_oe),
    .dev_sda_oe(tsi_if_inst.dev_sda_oe), .scl(tsi_if_inst.scl), .sda(tsi_if_inst.sda));
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  // one count per stored byte; unmapped writes must not pulse
  always @(posedge clk_i) begin
    if (wr_pulse === 1'b1) begin
      n_wr++;
    end
  end
  task check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // ****************************************
  // bus and link helpers
  // ****************************************
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_i);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk_i); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_i); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task wait_idle(output logic [31:0] s);
    do ahb(1'b0, `TSI_HOST_STATUS, 32'h0, s); while (s[`TSI_STAT_BUSY_BIT] !== 1'b0);
  endtask
  task xfer(input logic [11:0] c, output logic [31:0] s);
    wait_idle(s);
    ahb(1'b1, `TSI_HOST_CMD, {20'h0, c}, s);
    wait_idle(s);
  endtask
  task peek(input logic [7:0] i, input logic [7:0] exp);
    @(posedge clk_i);
    rd_index <= i;
    repeat (2) @(posedge clk_i);
    check({24'h0, rd_data}, {24'h0, exp});
  endtask
  task conclude;
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #400000;
    n_errors++;
    $display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    conclude;
  end
  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (6) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    check({30'h0, tsi_if_inst.scl, tsi_if_inst.sda}, 32'h3);
    ahb(1'b0, `TSI_HOST_STATUS, 32'h0, st);
    check(st, 32'h0);
    peek(`TSI_OFS_TOUCH_LEVEL_CH0_CH1, `TSI_REG_RESET);
    $display("reset values done");
    for (int i = 0; i < 28; i++) begin
      xfer(ROWS[i].cmd, st);
      check({23'h0, st[`TSI_STAT_NACK_BIT], st[15:8]}, {23'h0, ROWS[i].nack, ROWS[i].rx});
    end
    $display("link table done");
    peek(8'h02, 8'h33);
    peek(8'h03, 8'h22);
    peek(8'h00, 8'ha5);
    peek(8'h10, 8'h00);
    check({16'h0, wr_index, wr_data}, 32'h00a5);
    check(n_wr, 32'h3);
    $display("register contents done");
    ahb(1'b1, `TSI_HOST_CMD, 32'h3f2, st);
    ahb(1'b1, `TSI_HOST_CMD, 32'h1f0, st);
    wait_idle(st);
    check({23'h0, st[`TSI_STAT_NACK_BIT], st[15:8]}, 32'h1f2);
    repeat (4) @(posedge clk_i);
    check({30'h0, tsi_if_inst.scl, dev_busy}, 32'h2);
    ahb(1'b1, 8'h08, 32'h5, st);
    ahb(1'b0, 8'h08, 32'h0, st);
    check(st, 32'h0);
    $display("refused commands done");
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    check(hrdata, 32'h0);
    check({29'h0, hresp, dev_busy, tsi_if_inst.dev_sda_oe}, 32'h0);
    reset_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    peek(8'h02, `TSI_REG_RESET);
    xfer(12'h3f0, st);
    check({23'h0, st[`TSI_STAT_NACK_BIT], st[15:8]}, 32'h0f0);
    $display("mid-run reset done");
    conclude;
  end
endmodule

// [bench/tsi_link_asserts.sv]
// checker for the two-wire link between host and sensor ends
`timescale 1ns/1ns
module tsi_link_asserts (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic host_scl_oe,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  logic scl_q, sda_q, frame, first, hit, rd;
  logic [7:0] sh, low_cnt;
  logic [3:0] bitn;
  wire rise = scl && !scl_q;
  wire start = scl && scl_q && sda_q && !sda;
  wire stop = scl && scl_q && !sda_q && sda;
  wire ninth = rise && (bitn == 4'h8);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // ****************************************
  // bit position on the wire
  // ****************************************
  // stop and repeated start also raise scl; start clears the count
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      {scl_q, sda_q, frame, first, hit, rd} <= 6'h30;
      {sh, low_cnt, bitn} <= 20'h0;
    end else begin
      {scl_q, sda_q} <= {scl, sda};
      low_cnt <= scl ? 8'h00 : (low_cnt == 8'hff ? low_cnt : low_cnt + 8'h01);
      frame <= start ? 1'b1 : (stop ? 1'b0 : frame);
      if (start) begin
        bitn <= 4'h0;
        first <= 1'b1;
      end else if (ninth) begin
        bitn <= 4'h0;
        first <= 1'b0;
        if (first) begin
          hit <= (sh[7:1] == 7'h78);
          rd <= sh[0];
        end
      end else if (rise) begin
        bitn <= bitn + 4'h1;
        sh <= {sh[6:0], sda};
      end
    end
  end
  // ****************************************
  // assertions
  // ****************************************
  AST_ADDR_ACK: assert property (ninth && first |-> sda == (sh[7:1] != 7'h78))
    else $error("address byte acknowledge wrong");
  AST_WDATA_ACK: assert property (ninth && !first && hit && !rd |-> !sda)
    else $error("written byte not acknowledged");
  AST_NO_FIGHT: assert property (!(scl && host_sda_oe && dev_sda_oe))
    else $error("both ends pull data while clock high");
  AST_DEV_HOLD: assert property ($changed(dev_sda_oe) |-> !scl && !$past(scl))
    else $error("device moved data while clock high");
  AST_DEV_TURN: assert property ($changed(dev_sda_oe) |-> low_cnt >= 8'h2 && low_cnt <= 8'h5)
    else $error("device data change late after clock fall");
  AST_IDLE_QUIET: assert property (!frame |-> !dev_sda_oe)
    else $error("device drives data outside a frame");
  AST_SCL_HIGH: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high phase too short");
  AST_STOP_IDLE: assert property (stop |=> (sda && scl && !dev_sda_oe) [*8])
    else $error("lines not idle after stop");
endmodule

// [rtl/tsi_dev.sv]
// sensor end: two-wire slave holding the register map
`timescale 1ns/1ns
`include "tsi_regs.svh"
module tsi_dev import tsi_pkg::*; (
  input wire logic clk_i,
  input wire logic reset_i,
  tsi_if.dev link,
  input wire logic [7:0] rd_index_i,
  output logic [7:0] rd_data_o,
  output logic wr_pulse_o,
  output logic [7:0] wr_index_o,
  output logic [7:0] wr_data_o,
  output logic busy_o
);

  // ****************************************************************
  // register map
  // ****************************************************************
  logic [7:0] regs [0:255];

  function automatic logic tsi_mapped(input logic [7:0] idx);
    case (idx)
      `TSI_OFS_THRESHOLD_BASE, `TSI_OFS_THRESHOLD_INCREMENT,
      `TSI_OFS_TOUCH_LEVEL_CH0_CH1, `TSI_OFS_TOUCH_LEVEL_CH2_CH3,
      `TSI_OFS_TOUCH_LEVEL_CH4_CH5, `TSI_OFS_TOUCH_LEVEL_CH6_CH7,
      `TSI_OFS_GENERAL_CONFIG_A, `TSI_OFS_GENERAL_CONFIG_B,
      `TSI_OFS_BASELINE_RESET_MASK, `TSI_OFS_CHANNEL_FREEZE_MASK,
      `TSI_OFS_KEY_OUTPUT_CFG_LOW, `TSI_OFS_KEY_OUTPUT_CFG_HIGH,
      `TSI_OFS_PIN_DRIVE_CHANNELS, `TSI_OFS_PIN_DRIVE_OUTPUT,
      `TSI_OFS_STATE_PROBE, `TSI_OFS_POWER_MODE_SELECT,
      `TSI_OFS_KEY_HOLD_DURATION, `TSI_OFS_FEATURE_OPTIONS,
      `TSI_OFS_ACCUMULATE_COUNT, `TSI_OFS_IDLE_ENTRY_DELAY,
      `TSI_OFS_IDLE_WAKE_LEVEL, `TSI_OFS_IDLE_WAKE_COUNT_LEVEL,
      `TSI_OFS_DEBOUNCE_COUNT, `TSI_OFS_RELEASE_IRQ_DELAY,
      `TSI_OFS_FREQUENCY_STORE, `TSI_OFS_CALIBRATION_RESTART: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // ****************************************************************
  // pin synchronisers and bus conditions
  // ****************************************************************
  logic [2:0] scl_sync;
  logic [2:0] sda_sync;
  wire scl_s = scl_sync[1];
  wire scl_d = scl_sync[2];
  wire sda_s = sda_sync[1];
  wire sda_d = sda_sync[2];

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
    end else begin
      scl_sync <= {scl_sync[1:0], link.scl};
      sda_sync <= {sda_sync[1:0], link.sda};
    end
  end

  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  // data moving while clock high marks start or stop
  wire start_det = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_det = scl_s & scl_d & ~sda_d & sda_s;

  // ****************************************************************
  // byte engine
  // ****************************************************************
  tsi_dev_state_t state;
  logic [3:0] bitcnt;
  logic [7:0] shreg;
  logic [7:0] ptr;
  logic sda_oe;

  wire active = (state != DS_IDLE);
  wire in_byte = (bitcnt < 4'd8);
  wire ack_slot = (bitcnt == 4'd8);
  wire ack_end = (bitcnt == 4'd9);
  wire reading = (state == DS_RDATA);
  wire [7:0] rd_byte = tsi_mapped(ptr) ? regs[ptr] : 8'h00;
  wire addr_hit = (shreg[7:1] == `TSI_SLAVE_ADDR);
  wire dir_read = (shreg[0] == `TSI_DIR_READ);
  wire recv_done = active & scl_fall & ack_slot & ~stop_det & ~start_det;
  wire mem_we = recv_done & (state == DS_WDATA) & tsi_mapped(ptr);
  wire master_nack = active & scl_rise & ack_slot & reading & sda_s;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state <= DS_IDLE;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      ptr <= 8'h00;
      sda_oe <= 1'b0;
    end else if (stop_det) begin
      state <= DS_IDLE;
      bitcnt <= 4'h0;
      sda_oe <= 1'b0;
    end else if (start_det) begin
      state <= DS_ADDR;
      bitcnt <= 4'h0;
      sda_oe <= 1'b0;
    end else if (active && scl_rise) begin
      bitcnt <= bitcnt + 4'h1;
      if (in_byte && !reading) begin
        shreg <= {shreg[6:0], sda_s};
      end
      if (master_nack) begin
        state <= DS_IDLE;
      end else if (ack_slot && reading) begin
        shreg <= rd_byte;
        ptr <= ptr + 8'h01;
      end
    end else if (active && scl_fall) begin
      if (ack_slot) begin
        sda_oe <= 1'b0;
        unique case (state)
          DS_ADDR: begin
            if (addr_hit) begin
              sda_oe <= 1'b1;
              // first byte loads on the ack rise; loading here too would skip one
              if (dir_read) begin
                state <= DS_RDATA;
              end else begin
                state <= DS_INDEX;
              end
            end else begin
              state <= DS_IDLE;
            end
          end
          DS_INDEX: begin
            ptr <= shreg;
            sda_oe <= 1'b1;
            state <= DS_WDATA;
          end
          DS_WDATA: begin
            ptr <= ptr + 8'h01;
            sda_oe <= 1'b1;
          end
          DS_RDATA: begin
            sda_oe <= 1'b0;
          end
          default: begin
            state <= DS_IDLE;
          end
        endcase
      end else if (ack_end) begin
        bitcnt <= 4'h0;
        // first read bit is the MSB
        sda_oe <= reading ? ~shreg[7] : 1'b0;
      end else if (reading && bitcnt != 4'h0) begin
        shreg <= {shreg[6:0], 1'b0};
        sda_oe <= ~shreg[6];
      end
    end
  end

  // ****************************************************************
  // register storage
  // ****************************************************************
  // unmapped offsets keep no storage effect and read as zero
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      for (int i = 0; i < 256; i++) begin
        regs[i] <= `TSI_REG_RESET;
      end
    end else if (mem_we) begin
      regs[ptr] <= shreg;
    end
  end

  // ****************************************************************
  // user side
  // ****************************************************************
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rd_data_o <= 8'h00;
      wr_pulse_o <= 1'b0;
      wr_index_o <= 8'h00;
      wr_data_o <= 8'h00;
      busy_o <= 1'b0;
    end else begin
      rd_data_o <= tsi_mapped(rd_index_i) ? regs[rd_index_i] : 8'h00;
      wr_pulse_o <= mem_we;
      if (mem_we) begin
        wr_index_o <= ptr;
        wr_data_o <= shreg;
      end
      busy_o <= active;
    end
  end

  // open-drain: only ever pulls low
  assign link.dev_sda_out = 1'b0;
  assign link.dev_sda_oe = sda_oe;

endmodule

// [rtl/tsi_host.sv]
// host end: byte-level two-wire master commanded over AHB-Lite
`timescale 1ns/1ns
`include "tsi_regs.svh"
module tsi_host import tsi_pkg::*; (
  input wire logic clk_i,
  input wire logic reset_i,
  tsi_if.host link,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic [31:0] hrdata_o,
  output logic hresp_o
);

  localparam int QTR_CYC = (`TSI_QUARTER_NS + `TSI_CLK_NS - 1) / `TSI_CLK_NS;
  localparam logic [4:0] QTR_LAST = 5'(QTR_CYC - 1);

  // ****************************************************************
  // bus slave
  // ****************************************************************
  tsi_host_state_t state;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic [11:0] cmd;
  logic [7:0] rx;
  logic nack;

  wire busy = (state != HS_IDLE);
  wire addr_ok = hsel_i & htrans_i[1] & hready_i;
  wire [31:0] rd_mux = (haddr_i[7:0] == `TSI_HOST_STATUS) ? {16'h0000, rx, 6'h00, nack, busy} :
                       (haddr_i[7:0] == `TSI_HOST_CMD) ? {20'h00000, cmd} : 32'h00000000;
  // a command written while busy is dropped
  wire cmd_go = wr_pend & (wr_addr == `TSI_HOST_CMD) & ~busy;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata_o <= 32'h00000000;
    end else begin
      wr_pend <= addr_ok & hwrite_i;
      wr_addr <= haddr_i[7:0];
      if (addr_ok && !hwrite_i) begin
        hrdata_o <= rd_mux;
      end
    end
  end

  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;

  // ****************************************************************
  // link engine
  // ****************************************************************
  logic [1:0] sda_sync;
  logic [4:0] qcnt;
  logic [1:0] q;
  logic [3:0] bitn;
  logic [7:0] txsh;
  logic scl_oe;
  logic sda_oe;

  wire sda_s = sda_sync[1];
  wire tick = (qcnt == QTR_LAST);
  wire do_read = cmd[`TSI_CMD_READ_BIT];
  wire data_bit = (bitn < 4'd8);
  // master leaves ack high on last read byte
  wire ack_drive = do_read & ~cmd[`TSI_CMD_NACK_BIT];
  // MSB first, receiver acks in ninth clock
  wire bit_drive = data_bit ? (~do_read & ~txsh[7]) : ack_drive;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sda_sync <= 2'h3;
    end else begin
      sda_sync <= {sda_sync[0], link.sda};
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      qcnt <= 5'h00;
    end else if (cmd_go || tick) begin
      qcnt <= 5'h00;
    end else begin
      qcnt <= qcnt + 5'h01;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state <= HS_IDLE;
      cmd <= 12'h000;
      q <= 2'h0;
      bitn <= 4'h0;
      txsh <= 8'h00;
      rx <= 8'h00;
      nack <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else if (cmd_go) begin
      cmd <= hwdata_i[11:0];
      txsh <= hwdata_i[7:0];
      q <= 2'h0;
      bitn <= 4'h0;
      state <= hwdata_i[`TSI_CMD_START_BIT] ? HS_START : HS_BIT;
    end else if (tick && busy) begin
      q <= q + 2'h1;
      unique case (state)
        HS_START: begin
          unique case (q)
            2'h0: sda_oe <= 1'b0;
            2'h1: scl_oe <= 1'b0;
            2'h2: sda_oe <= 1'b1;
            2'h3: begin
              scl_oe <= 1'b1;
              state <= HS_BIT;
            end
          endcase
        end
        HS_BIT: begin
          unique case (q)
            2'h0: sda_oe <= bit_drive;
            2'h1: scl_oe <= 1'b0;
            2'h2: begin
              if (data_bit) begin
                rx <= {rx[6:0], sda_s};
              end else begin
                nack <= sda_s;
              end
            end
            2'h3: begin
              scl_oe <= 1'b1;
              bitn <= bitn + 4'h1;
              txsh <= {txsh[6:0], 1'b0};
              if (!data_bit) begin
                state <= cmd[`TSI_CMD_STOP_BIT] ? HS_STOP : HS_IDLE;
              end
            end
          endcase
        end
        HS_STOP: begin
          unique case (q)
            2'h0: sda_oe <= 1'b1;
            2'h1: scl_oe <= 1'b0;
            2'h2: sda_oe <= 1'b0;
            2'h3: state <= HS_IDLE;
          endcase
        end
        HS_IDLE: begin
          q <= 2'h0;
        end
      endcase
    end
  end

  assign link.host_scl_out = 1'b0;
  assign link.host_scl_oe = scl_oe;
  assign link.host_sda_out = 1'b0;
  assign link.host_sda_oe = sda_oe;

endmodule

// [rtl/tsi_if.sv]
// two-wire link between the host controller and the sensor register port
`timescale 1ns/1ns
interface tsi_if;
  logic host_scl_out;
  logic host_scl_oe;
  logic host_sda_out;
  logic host_sda_oe;
  logic dev_sda_out;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  // open-drain wired-and, pull-up when nobody drives
  assign scl = host_scl_oe ? host_scl_out : 1'b1;
  assign sda = (host_sda_oe ? host_sda_out : 1'b1) & (dev_sda_oe ? dev_sda_out : 1'b1);

  modport host (output host_scl_out, output host_scl_oe, output host_sda_out, output host_sda_oe,
                input scl, input sda);
  modport dev (output dev_sda_out, output dev_sda_oe, input scl, input sda);
endinterface

// [rtl/tsi_pkg.sv]
// state types shared by both ends of the touch sensor register port
package tsi_pkg;
  typedef enum logic [2:0] {
    DS_IDLE = 3'b000,
    DS_ADDR = 3'b001,
    DS_INDEX = 3'b010,
    DS_WDATA = 3'b011,
    DS_RDATA = 3'b100
  } tsi_dev_state_t;

  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_START = 2'b01,
    HS_BIT = 2'b10,
    HS_STOP = 2'b11
  } tsi_host_state_t;
endpackage

// [rtl/tsi_regs.svh]
// register offsets, reset values and timing constants of the touch sensor register port
`ifndef TSI_REGS_SVH
`define TSI_REGS_SVH

// ****************************************************************
// link addressing
// ****************************************************************
`define TSI_SLAVE_ADDR 7'h78
`define TSI_DIR_WRITE 1'b0
`define TSI_DIR_READ 1'b1

// ****************************************************************
// device register offsets
// ****************************************************************
`define TSI_OFS_THRESHOLD_BASE 8'h00
`define TSI_OFS_THRESHOLD_INCREMENT 8'h01
`define TSI_OFS_TOUCH_LEVEL_CH0_CH1 8'h02
`define TSI_OFS_TOUCH_LEVEL_CH2_CH3 8'h03
`define TSI_OFS_TOUCH_LEVEL_CH4_CH5 8'h04
`define TSI_OFS_TOUCH_LEVEL_CH6_CH7 8'h05
`define TSI_OFS_GENERAL_CONFIG_A 8'h06
`define TSI_OFS_GENERAL_CONFIG_B 8'h07
`define TSI_OFS_BASELINE_RESET_MASK 8'h08
`define TSI_OFS_CHANNEL_FREEZE_MASK 8'h09
`define TSI_OFS_KEY_OUTPUT_CFG_LOW 8'h0a
`define TSI_OFS_KEY_OUTPUT_CFG_HIGH 8'h0b
`define TSI_OFS_PIN_DRIVE_CHANNELS 8'h0c
`define TSI_OFS_PIN_DRIVE_OUTPUT 8'h0d
`define TSI_OFS_STATE_PROBE 8'h0e
`define TSI_OFS_POWER_MODE_SELECT 8'h1d
`define TSI_OFS_KEY_HOLD_DURATION 8'h1e
`define TSI_OFS_FEATURE_OPTIONS 8'h1f
`define TSI_OFS_ACCUMULATE_COUNT 8'h20
`define TSI_OFS_IDLE_ENTRY_DELAY 8'h23
`define TSI_OFS_IDLE_WAKE_LEVEL 8'h24
`define TSI_OFS_IDLE_WAKE_COUNT_LEVEL 8'h25
`define TSI_OFS_DEBOUNCE_COUNT 8'h26
`define TSI_OFS_RELEASE_IRQ_DELAY 8'h27
`define TSI_OFS_FREQUENCY_STORE 8'h2a
`define TSI_OFS_CALIBRATION_RESTART 8'hfe
`define TSI_REG_RESET 8'h00

// ****************************************************************
// host controller registers on the system bus
// ****************************************************************
`define TSI_HOST_CMD 8'h00
`define TSI_HOST_STATUS 8'h04
`define TSI_CMD_BYTE_LSB 0
`define TSI_CMD_START_BIT 8
`define TSI_CMD_STOP_BIT 9
`define TSI_CMD_READ_BIT 10
`define TSI_CMD_NACK_BIT 11
`define TSI_STAT_BUSY_BIT 0
`define TSI_STAT_NACK_BIT 1
`define TSI_STAT_RX_LSB 8

// ****************************************************************
// link timing
// ****************************************************************
`define TSI_CLK_NS 8
`define TSI_QUARTER_NS 64

`endif
